// ===== verilog/t1s_status_counters.sv
// What this block does
// [R01] Set rx multiframe flag on every receive multiframe boundary.
// [R02] Set tx multiframe flag on every transmit multiframe boundary.
// [R03] One-second flag from rx clock count: 999, 999, 1002 ms.
// [R04] Set rx link full flag after eight link bits gathered.
// [R05] Set tx link empty flag when tx byte fully sent.
// [R06] Set match flag when completed rx byte equals either pattern.
// [R07] Set abort flag on eight consecutive ones on link.
// [R08] Set rx clock lost flag after about two microseconds idle.
// [R09] Mask A: one enable bit per line-status event, 1 enables.
// [R10] Mask B: one enable bit per status B flag, same positions.
// [R11] All counters update on each one-second boundary.
// [R12] Counters saturate at maximum, never wrap within an interval.
// [R13] Line counter 16 bits, high byte 0x23, low byte 0x24.
// [R14] Count BPVs, plus 16 or 8 zero runs; skip substitution words.
// [R15] Line counter keeps counting while sync is lost.
// [R16] ESF mode: path counter counts CRC6 errors, 12 bits.
// [R17] D4 mode: path counter counts Ft errors, optionally Fs too.
// [R18] Path counter stops while sync is lost.
// [R19] Path bits 11:8 low nibble of 0x25, bits 7:0 at 0x26.
// [R20] Loss option: count multiframes out of sync, even when lost.
// [R21] Alternate: count Ft or FPS errors, disabled while lost.
// [R22] Out-of-sync counter 12 bits: top nibble 0x25, low 0x27.
// [R23] Option bit 0 selects framing errors, 1 selects multiframes.
// [R24] Enabled flagged event drives active-low interrupt low.
// [R25] At boundary copy running count to readable, restart from zero.
// [R26] Host reads counters within a second, high byte first.
`timescale 1ns/1ps
`default_nettype none
`include "t1s_map.svh"
module t1s_status_counters #(
   parameter int SEC_SHORT_CYC = `T1S_RX_HZ / 1000 * `T1S_SHORT_MS,
   parameter int SEC_LONG_CYC  = `T1S_RX_HZ / 1000 * `T1S_LONG_MS
) (
   input  wire logic                  clk,        // 20 MHz clock
   input  wire logic                  arst_n,     // Async reset
   input  wire logic                  rxClkPin,   // Recovered rx clock
   input  wire t1s_pkg::t1s_rx_ev_t   rxEv,       // Rx framer events
   input  wire logic                  txMfStb,    // Tx multiframe pulse
   input  wire logic                  txLinkSent, // Tx byte sent pulse
   input  wire t1s_pkg::t1s_cfg_t     cfg,        // Mode selects
   input  wire logic [7:0]            matchPatA,  // Link match pattern A
   input  wire logic [7:0]            matchPatB,  // Link match pattern B
   input  wire logic [7:0]            lineStatus, // Line-status flags
   input  wire t1s_pkg::t1s_host_req_t hostReq,   // Control port access
   output logic [7:0]                 rdData,     // Read data
   output logic [7:0]                 rxLinkByte, // Last rx link byte
   output logic                       intN        // Interrupt, low active
);
   import t1s_pkg::*;

   localparam int RX_CLOCK_LOST_CYC =
      (`T1S_RX_CLOCK_LOST_NS + `T1S_CLK_NS - 1) / `T1S_CLK_NS;
   localparam logic [15:0] CNT_MAX [3] =
      '{`T1S_LCV_MAX, `T1S_PCV_MAX, `T1S_OOF_MAX};

   // Timer and clock watch
   logic        rxClkPrevReg, rxClkPrevNext;
   logic [20:0] secCntReg, secCntNext;
   logic [1:0]  phaseReg, phaseNext;
   logic [5:0]  idleCntReg, idleCntNext;
   logic        rxEdge, rxTrans, secTick, clkLost;
   logic [20:0] secLimit;

   always_comb begin
      rxEdge        = rxClkPin & ~rxClkPrevReg;
      rxTrans       = rxClkPin ^ rxClkPrevReg;
      rxClkPrevNext = rxClkPin;
      secLimit      = (phaseReg == `T1S_LONG_PHASE)
                    ? 21'(SEC_LONG_CYC - 1) : 21'(SEC_SHORT_CYC - 1);
      secTick       = rxEdge && (secCntReg == secLimit); // [R03]
      secCntNext    = secCntReg;
      phaseNext     = phaseReg;
      if (secTick) begin
         secCntNext = '0;
         phaseNext  = (phaseReg == `T1S_LONG_PHASE)
                    ? 2'h0 : phaseReg + 2'h1; // [R03]
      end else if (rxEdge) begin
         secCntNext = secCntReg + 21'h0_0001;
      end
      // Fires once per stall, not every cycle of it
      clkLost     = !rxTrans && (idleCntReg == 6'(RX_CLOCK_LOST_CYC - 1)); // [R08]
      idleCntNext = idleCntReg;
      if (rxTrans)
         idleCntNext = '0;
      else if (idleCntReg != 6'(RX_CLOCK_LOST_CYC))
         idleCntNext = idleCntReg + 6'h01;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rxClkPrevReg <= 1'b0;
         secCntReg    <= '0;
         phaseReg     <= '0;
         idleCntReg   <= '0;
      end else begin
         rxClkPrevReg <= rxClkPrevNext;
         secCntReg    <= secCntNext;
         phaseReg     <= phaseNext;
         idleCntReg   <= idleCntNext;
      end
   end

   // Receive data link: LSB arrives first
   logic [7:0] shiftReg, shiftNext;
   logic [2:0] bitCntReg, bitCntNext;
   logic [3:0] onesReg, onesNext;
   logic [7:0] rxLinkByteNext;
   logic       linkFull, linkMatch, linkAbort;

   always_comb begin
      shiftNext      = shiftReg;
      bitCntNext     = bitCntReg;
      onesNext       = onesReg;
      rxLinkByteNext = rxLinkByte;
      linkFull       = 1'b0;
      linkMatch      = 1'b0;
      linkAbort      = 1'b0;
      if (rxEv.linkBitStb) begin
         shiftNext  = {rxEv.linkBit, shiftReg[7:1]};
         bitCntNext = bitCntReg + 3'h1;
         if (bitCntReg == 3'(`T1S_LINK_BITS - 1)) begin
            linkFull       = 1'b1; // [R04]
            rxLinkByteNext = shiftNext;
            linkMatch      = (shiftNext == matchPatA)
                          || (shiftNext == matchPatB); // [R06]
         end
         if (!rxEv.linkBit)
            onesNext = '0;
         else if (onesReg != 4'(`T1S_LINK_BITS))
            onesNext = onesReg + 4'h1;
         // One abort per run of ones
         linkAbort = rxEv.linkBit
                  && (onesReg == 4'(`T1S_LINK_BITS - 1)); // [R07]
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         shiftReg   <= '0;
         bitCntReg  <= '0;
         onesReg    <= '0;
         rxLinkByte <= '0;
      end else begin
         shiftReg   <= shiftNext;
         bitCntReg  <= bitCntNext;
         onesReg    <= onesNext;
         rxLinkByte <= rxLinkByteNext;
      end
   end

   // Counter increments
   logic [4:0] zeroRunReg, zeroRunNext;
   logic [4:0] zeroThr;
   logic       zeroHit;
   logic [2:0] cntInc;

   always_comb begin
      zeroThr = cfg.zeroSubEnable ? 5'(`T1S_ZRUN_SUB)
                                  : 5'(`T1S_ZRUN_PLAIN); // [R14]
      zeroRunNext = zeroRunReg;
      zeroHit     = 1'b0;
      if (rxEv.lineBitStb) begin
         if (rxEv.lineBitOne) begin
            zeroRunNext = '0;
         end else begin
            if (zeroRunReg != 5'h1F)
               zeroRunNext = zeroRunReg + 5'h01;
            zeroHit = cfg.countZerosSel
                   && (zeroRunReg + 5'h01 == zeroThr); // [R14]
         end
      end
      // Line counter ignores sync state
      cntInc[0] = (rxEv.bpv && !(cfg.zeroSubEnable && rxEv.subWord))
               || zeroHit; // [R14] [R15]
      cntInc[1] = !rxEv.frameLost
               && (cfg.esfModeSel ? rxEv.crcErr // [R16]
                  : rxEv.ftErr || (cfg.fsErrCountSel && rxEv.fsErr));
      // [R17] [R18] above
      if (cfg.frameLossCountSel)
         cntInc[2] = rxEv.mfBoundary && rxEv.frameLost; // [R20] [R23]
      else
         cntInc[2] = !rxEv.frameLost
                  && (cfg.esfModeSel ? rxEv.fpsErr
                                     : rxEv.ftErr); // [R21] [R23]
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         zeroRunReg <= '0;
      else
         zeroRunReg <= zeroRunNext;
   end

   logic [15:0] runReg [3];
   logic [15:0] holdReg [3];

   for (genvar g = 0; g < 3; g++) begin : gCnt
      logic [15:0] runNext, holdNext;
      always_comb begin
         runNext  = runReg[g];
         holdNext = holdReg[g];
         if (secTick) begin
            holdNext = runReg[g]; // [R11] [R25]
            runNext  = {15'h0000, cntInc[g]}; // [R25]
         end else if (cntInc[g] && runReg[g] != CNT_MAX[g]) begin
            runNext = runReg[g] + 16'h0001; // [R12]
         end
      end
      always_ff @(posedge clk or negedge arst_n) begin
         if (!arst_n) begin
            runReg[g]  <= '0;
            holdReg[g] <= '0;
         end else begin
            runReg[g]  <= runNext;
            holdReg[g] <= holdNext;
         end
      end
   end

   // Flags, masks and host reads
   logic [7:0] statusBReg, statusBNext;
   logic [7:0] maskAReg, maskANext;
   logic [7:0] maskBReg, maskBNext;
   logic [7:0] rdDataNext;
   logic [7:0] statusSet;

   always_comb begin
      statusSet                = '0;
      statusSet[`T1S_B_RMF]    = rxEv.mfBoundary; // [R01]
      statusSet[`T1S_B_TMF]    = txMfStb; // [R02]
      statusSet[`T1S_B_SEC]    = secTick; // [R03]
      statusSet[`T1S_B_RFULL]  = linkFull; // [R04]
      statusSet[`T1S_B_TEMPTY] = txLinkSent; // [R05]
      statusSet[`T1S_B_MATCH]  = linkMatch; // [R06]
      statusSet[`T1S_B_ABORT]  = linkAbort; // [R07]
      statusSet[`T1S_B_RX_CLOCK_LOST]   = clkLost; // [R08]
      statusBNext = statusBReg;
      // Read clears; an event in the same cycle survives
      if (hostReq.rd && hostReq.addr == `T1S_A_STATUS_B)
         statusBNext = '0;
      statusBNext = statusBNext | statusSet;
      maskANext   = maskAReg;
      maskBNext   = maskBReg;
      if (hostReq.wr && hostReq.addr == `T1S_A_MASK_A)
         maskANext = hostReq.wdata; // [R09]
      if (hostReq.wr && hostReq.addr == `T1S_A_MASK_B)
         maskBNext = hostReq.wdata; // [R10]
      rdDataNext = rdData;
      if (hostReq.rd) begin
         case (hostReq.addr)
            `T1S_A_STATUS_B: rdDataNext = statusBReg;
            `T1S_A_LCV_HI:   rdDataNext = holdReg[0][15:8]; // [R13]
            `T1S_A_LCV_LO:   rdDataNext = holdReg[0][7:0]; // [R13]
            `T1S_A_PCV_HI:   rdDataNext = {holdReg[2][11:8],
                                           holdReg[1][11:8]}; // [R19] [R22]
            `T1S_A_PCV_LO:   rdDataNext = holdReg[1][7:0]; // [R19]
            `T1S_A_OOF_LO:   rdDataNext = holdReg[2][7:0]; // [R22]
            `T1S_A_MASK_B:   rdDataNext = maskBReg;
            `T1S_A_MASK_A:   rdDataNext = maskAReg;
            default:         rdDataNext = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         statusBReg <= '0;
         maskAReg   <= `T1S_MASK_RST;
         maskBReg   <= `T1S_MASK_RST;
         rdData     <= '0;
      end else begin
         statusBReg <= statusBNext;
         maskAReg   <= maskANext;
         maskBReg   <= maskBNext;
         rdData     <= rdDataNext;
      end
   end

   // Line-status inputs are levels, so gated directly
   assign intN = ~(|(statusBReg & maskBReg)
                 | |(lineStatus & maskAReg)); // [R09] [R10] [R24]

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   a_rmf_set: assert property ( // [R01]
      rxEv.mfBoundary |=> statusBReg[`T1S_B_RMF])
      else $error("rx multiframe flag not set");
   a_tmf_set: assert property ( // [R02]
      txMfStb |=> statusBReg[`T1S_B_TMF])
      else $error("tx multiframe flag not set");
   a_sec_tick: assert property ( // [R03]
      rxEdge && secCntReg == 21'(SEC_SHORT_CYC - 1)
      && phaseReg != `T1S_LONG_PHASE |=> statusBReg[`T1S_B_SEC]
      && secCntReg == 21'h0_0000)
      else $error("short second not ended");
   a_sec_long: assert property ( // [R03]
      rxEdge && secCntReg == 21'(SEC_SHORT_CYC - 1)
      && phaseReg == `T1S_LONG_PHASE
      |=> secCntReg == 21'(SEC_SHORT_CYC) && phaseReg == `T1S_LONG_PHASE)
      else $error("long second ended early");
   a_link_full: assert property ( // [R04]
      rxEv.linkBitStb && bitCntReg == 3'h7 |=>
      statusBReg[`T1S_B_RFULL]
      && rxLinkByte == {$past(rxEv.linkBit), $past(shiftReg[7:1])})
      else $error("link byte not captured");
   a_link_abort: assert property ( // [R07]
      rxEv.linkBitStb && rxEv.linkBit && onesReg == 4'h7 |=>
      statusBReg[`T1S_B_ABORT])
      else $error("abort flag missing");
   a_clk_lost: assert property ( // [R08]
      !rxTrans && idleCntReg == 6'(RX_CLOCK_LOST_CYC - 1) |=>
      statusBReg[`T1S_B_RX_CLOCK_LOST])
      else $error("clock loss not flagged");
   a_cnt_copy: assert property ( // [R11]
      secTick |=> holdReg[0] == $past(runReg[0])
      && holdReg[1] == $past(runReg[1]))
      else $error("counter copy missed");
   a_cnt_sat: assert property ( // [R12]
      runReg[0] == `T1S_LCV_MAX && !secTick |=>
      runReg[0] == `T1S_LCV_MAX)
      else $error("line counter wrapped");
   a_path_hold: assert property ( // [R18]
      rxEv.frameLost && !secTick |=> $stable(runReg[1]))
      else $error("path counted while lost");
   a_irq_low: assert property ( // [R24]
      rxEv.mfBoundary && maskBReg[`T1S_B_RMF]
      && !(hostReq.wr && hostReq.addr == `T1S_A_MASK_B) |=> !intN)
      else $error("interrupt not asserted");
   a_tx_empty: assert property ( // [R05]
      txLinkSent |=> statusBReg[`T1S_B_TEMPTY])
      else $error("tx empty flag not set");
   a_link_match: assert property ( // [R06]
      rxEv.linkBitStb && bitCntReg == 3'h7
      && {rxEv.linkBit, shiftReg[7:1]} == matchPatA |=>
      statusBReg[`T1S_B_MATCH])
      else $error("match flag not set");
   a_mask_a_irq: assert property ( // [R09]
      |(lineStatus & maskAReg) |-> !intN)
      else $error("line-status interrupt missing");
   a_zero_run: assert property ( // [R14]
      cfg.countZerosSel && !cfg.zeroSubEnable && rxEv.lineBitStb
      && !rxEv.lineBitOne && zeroRunReg == 5'h0F && !secTick
      && runReg[0] != `T1S_LCV_MAX
      |=> runReg[0] == $past(runReg[0]) + 16'h0001)
      else $error("zero run not counted");
   a_line_lost: assert property ( // [R15]
      rxEv.frameLost && rxEv.bpv && !rxEv.subWord && !secTick
      && runReg[0] != `T1S_LCV_MAX
      |=> runReg[0] == $past(runReg[0]) + 16'h0001)
      else $error("line count stopped while lost");
   a_crc_count: assert property ( // [R16]
      cfg.esfModeSel && rxEv.crcErr && !rxEv.frameLost && !secTick
      && runReg[1] != `T1S_PCV_MAX
      |=> runReg[1] == $past(runReg[1]) + 16'h0001)
      else $error("crc error not counted");
   a_fs_count: assert property ( // [R17]
      !cfg.esfModeSel && cfg.fsErrCountSel && rxEv.fsErr
      && !rxEv.frameLost && !secTick && runReg[1] != `T1S_PCV_MAX
      |=> runReg[1] == $past(runReg[1]) + 16'h0001)
      else $error("fs error not counted");
   a_oof_count: assert property ( // [R20] [R23]
      cfg.frameLossCountSel && rxEv.mfBoundary && rxEv.frameLost
      && !secTick && runReg[2] != `T1S_OOF_MAX
      |=> runReg[2] == $past(runReg[2]) + 16'h0001)
      else $error("lost multiframe not counted");
   a_oof_hold: assert property ( // [R21]
      !cfg.frameLossCountSel && rxEv.frameLost && !secTick
      |=> $stable(runReg[2]))
      else $error("framing count ran while lost");
   a_cnt_restart: assert property ( // [R25]
      secTick |=> runReg[0] <= 16'h0001 && runReg[1] <= 16'h0001
      && runReg[2] <= 16'h0001)
      else $error("running count not restarted");
   a_read_pair: assert property ( // [R19] [R22]
      hostReq.rd && hostReq.addr == `T1S_A_PCV_HI |=>
      rdData == {$past(holdReg[2][11:8]), $past(holdReg[1][11:8])})
      else $error("shared byte misplaced");

   c_sec_tick:  cover property (secTick);
   c_abort:     cover property (linkAbort);
   c_match:     cover property (linkFull && linkMatch);
   c_clk_lost:  cover property (clkLost ##1 rxTrans);
   c_oof_lost:  cover property (cfg.frameLossCountSel
                                && rxEv.mfBoundary && rxEv.frameLost);
endmodule : t1s_status_counters
`default_nettype wire

// ===== verilog/t1s_map.svh
`ifndef T1S_MAP_SVH
`define T1S_MAP_SVH
`define T1S_A_STATUS_B 8'h21
`define T1S_A_LCV_HI   8'h23
`define T1S_A_LCV_LO   8'h24
`define T1S_A_PCV_HI   8'h25
`define T1S_A_PCV_LO   8'h26
`define T1S_A_OOF_LO   8'h27
`define T1S_A_MASK_B   8'h6F
`define T1S_A_MASK_A   8'h7F
`define T1S_MASK_RST   8'h00
`define T1S_B_RMF      7
`define T1S_B_TMF      6
`define T1S_B_SEC      5
`define T1S_B_RFULL    4
`define T1S_B_TEMPTY   3
`define T1S_B_MATCH    2
`define T1S_B_ABORT    1
`define T1S_B_RX_CLOCK_LOST     0
`define T1S_RX_HZ      1544000
`define T1S_SHORT_MS   999
`define T1S_LONG_MS    1002
`define T1S_LONG_PHASE 2'h2
`define T1S_CLK_NS     50
`define T1S_RX_CLOCK_LOST_NS    2000
`define T1S_LINK_BITS  8
`define T1S_ZRUN_PLAIN 16
`define T1S_ZRUN_SUB   8
`define T1S_LCV_MAX    16'hFFFF
`define T1S_PCV_MAX    16'h0FFF
`define T1S_OOF_MAX    16'h0FFF
`endif

// ===== verilog/t1s_pkg.sv
`default_nettype none
package t1s_pkg;
   typedef struct packed {
      logic mfBoundary; // Rx multiframe boundary pulse
      logic frameLost;  // Rx sync lost level
      logic linkBitStb; // Rx data-link bit strobe
      logic linkBit;    // Rx data-link bit value
      logic lineBitStb; // Rx line bit strobe
      logic lineBitOne; // Rx line bit is a mark
      logic bpv;        // Bipolar violation pulse
      logic subWord;    // Zero-substitution word seen
      logic crcErr;     // CRC6 error pulse
      logic ftErr;      // Terminal framing bit error
      logic fsErr;      // Signaling framing bit error
      logic fpsErr;     // Framing pattern seq. error
   } t1s_rx_ev_t;
   typedef struct packed {
      logic countZerosSel;
      logic zeroSubEnable;
      logic esfModeSel;
      logic fsErrCountSel;
      logic frameLossCountSel;
   } t1s_cfg_t;
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } t1s_host_req_t;
endpackage : t1s_pkg
`default_nettype wire

// ===== bench/tb_t1_status_irq_error_counters.sv
`timescale 1ns/1ps
`default_nettype none
module tb_t1_status_irq_error_counters;
   import t1s_pkg::*;
   localparam int          SHORT   = 10;
   localparam int          LONG    = 12;
   localparam logic [11:0] EV_MF   = 12'h800;
   localparam logic [11:0] EV_LINK = 12'h200;
   localparam logic [11:0] EV_LINE = 12'h080;
   localparam logic [11:0] EV_BPV  = 12'h020;
   localparam logic [11:0] EV_SUB  = 12'h010;
   localparam logic [11:0] EV_CRC  = 12'h008;
   localparam logic [11:0] EV_FT   = 12'h004;
   localparam logic [11:0] EV_FS   = 12'h002;
   localparam logic [11:0] EV_FPS  = 12'h001;
   logic          clk        = 1'b0;
   logic          arst_n     = 1'b0;
   logic          rxClkPin   = 1'b0;
   t1s_rx_ev_t    rxEv       = '0;
   logic          txMfStb    = 1'b0;
   logic          txLinkSent = 1'b0;
   t1s_cfg_t      cfg        = '0;
   logic [7:0]    matchPatA  = 8'h3C;
   logic [7:0]    matchPatB  = 8'h81;
   logic [7:0]    lineStatus = 8'h00;
   t1s_host_req_t hostReq    = '0;
   logic [7:0]    rdData;
   logic [7:0]    rxLinkByte;
   logic          intN;
   int            errors     = 0;
   int            n_checks   = 0;
   int            edgeCnt    = 0;
   int            phase      = 0;

   t1s_status_counters #(.SEC_SHORT_CYC(SHORT), .SEC_LONG_CYC(LONG)) dut_u (
      .clk(clk), .arst_n(arst_n), .rxClkPin(rxClkPin), .rxEv(rxEv),
      .txMfStb(txMfStb), .txLinkSent(txLinkSent), .cfg(cfg),
      .matchPatA(matchPatA), .matchPatB(matchPatB),
      .lineStatus(lineStatus), .hostReq(hostReq), .rdData(rdData),
      .rxLinkByte(rxLinkByte), .intN(intN));

   always #25 clk = ~clk;

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask : cyc

   task automatic check(input logic [7:0] g, input logic [7:0] e,
                        input string m);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("mismatch t=%0t %s got %h exp %h", $time, m, g, e);
      end
   endtask : check

   task automatic access(input logic w, input logic [7:0] a,
                         input logic [7:0] d);
      hostReq = '{rd: !w, wr: w, addr: a, wdata: d};
      cyc(1);
      hostReq = '0;
   endtask : access

   task automatic rdChk(input logic [7:0] a, input logic [7:0] e,
                        input logic [7:0] care);
      access(1'b0, a, 8'h00);
      check(rdData & care, e, $sformatf("read %h", a));
   endtask : rdChk

   task automatic chkInt(input logic e);
      check({7'h00, intN}, {7'h00, e}, "intN");
   endtask : chkInt

   task automatic pulseEv(input logic [11:0] m, input int n);
      repeat (n) begin
         rxEv = rxEv | m;
         cyc(1);
         rxEv = rxEv & ~m;
         cyc(1);
      end
   endtask : pulseEv

   task automatic lineBits(input int n, input logic one);
      rxEv.lineBitOne = one;
      pulseEv(EV_LINE, n);
   endtask : lineBits

   task automatic sendByte(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         rxEv.linkBit = b[i];
         pulseEv(EV_LINK, 1);
      end
      check(rxLinkByte, b, "link byte");
   endtask : sendByte

   // Bench mirrors the 10/10/12 edge schedule to know the next tick
   task automatic rxEdges(input int n);
      repeat (n) begin
         rxClkPin = 1'b1;
         cyc(2);
         rxClkPin = 1'b0;
         cyc(2);
         edgeCnt++;
         if (edgeCnt == ((phase == 2) ? LONG : SHORT)) begin
            edgeCnt = 0;
            phase = (phase + 1) % 3;
         end
      end
   endtask : rxEdges

   task automatic toTick();
      rxEdges(((phase == 2) ? LONG : SHORT) - edgeCnt - 1);
      rdChk(8'h21, 8'h00, 8'h20);
      rxEdges(1);
      rdChk(8'h21, 8'h20, 8'h20);
   endtask : toTick

   task automatic cntChk(input logic [15:0] l, input logic [11:0] p,
                         input logic [11:0] o);
      rdChk(8'h23, l[15:8], 8'hFF);
      rdChk(8'h24, l[7:0], 8'hFF);
      rdChk(8'h25, {o[11:8], p[11:8]}, 8'hFF);
      rdChk(8'h26, p[7:0], 8'hFF);
      rdChk(8'h27, o[7:0], 8'hFF);
   endtask : cntChk

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict

   initial begin
      repeat (80000) @(posedge clk);
      errors++;
      $display("mismatch t=%0t watchdog expired", $time);
      print_verdict();
   end

   initial begin
      repeat (12) @(posedge clk);
      #5;
      arst_n = 1'b1;
      rdChk(8'h6F, 8'h00, 8'hFF);
      rdChk(8'h7F, 8'h00, 8'hFF);
      rdChk(8'h21, 8'h00, 8'hFF);
      chkInt(1'b1);
      access(1'b1, 8'h23, 8'h55);
      rdChk(8'h23, 8'h00, 8'hFF);
      rdChk(8'h30, 8'h00, 8'hFF);
      access(1'b1, 8'h6F, 8'hA5);
      access(1'b1, 8'h7F, 8'h5A);
      rdChk(8'h6F, 8'hA5, 8'hFF);
      rdChk(8'h7F, 8'h5A, 8'hFF);
      access(1'b1, 8'h6F, 8'h00);
      access(1'b1, 8'h7F, 8'h00);
      $display("test registers done");
      // Second and clock-loss bits masked: they run on their own
      access(1'b0, 8'h21, 8'h00);
      pulseEv(EV_MF, 1);
      txMfStb = 1'b1;
      cyc(1);
      txMfStb = 1'b0;
      txLinkSent = 1'b1;
      cyc(1);
      txLinkSent = 1'b0;
      rdChk(8'h21, 8'hC8, 8'hDE);
      rdChk(8'h21, 8'h00, 8'hDE);
      sendByte(8'h3C);
      rdChk(8'h21, 8'h14, 8'h1E);
      sendByte(8'hFF);
      rdChk(8'h21, 8'h12, 8'h1E);
      sendByte(8'h81);
      rdChk(8'h21, 8'h14, 8'h1C);
      $display("test events done");
      rxEdges(1);
      access(1'b0, 8'h21, 8'h00);
      cyc(30);
      rdChk(8'h21, 8'h00, 8'h01);
      cyc(14);
      rdChk(8'h21, 8'h01, 8'h01);
      rdChk(8'h21, 8'h00, 8'h01);
      $display("test clock loss done");
      access(1'b1, 8'h6F, 8'h80);
      pulseEv(EV_MF, 1);
      chkInt(1'b0);
      access(1'b0, 8'h21, 8'h00);
      chkInt(1'b1);
      lineStatus = 8'h08;
      cyc(2);
      chkInt(1'b1);
      access(1'b1, 8'h7F, 8'h08);
      cyc(1);
      chkInt(1'b0);
      access(1'b1, 8'h7F, 8'hF7);
      cyc(1);
      chkInt(1'b1);
      lineStatus = 8'h00;
      $display("test interrupt done");
      toTick();
      // cfg order: zeros, substitution, esf, fs errors, loss count
      cfg = 5'b10101;
      pulseEv(EV_BPV, 3);
      lineBits(20, 1'b0);
      lineBits(1, 1'b1);
      pulseEv(EV_CRC, 2);
      pulseEv(EV_MF, 1);
      rxEv.frameLost = 1'b1;
      pulseEv(EV_BPV, 1);
      pulseEv(EV_CRC, 1);
      pulseEv(EV_MF, 2);
      rxEv.frameLost = 1'b0;
      toTick();
      cntChk(16'h0005, 12'h002, 12'h002);
      cfg = 5'b11010;
      pulseEv(EV_FT, 1);
      pulseEv(EV_FS, 1);
      pulseEv(EV_FPS, 1);
      lineBits(8, 1'b0);
      lineBits(1, 1'b1);
      pulseEv(EV_BPV | EV_SUB, 1);
      pulseEv(EV_BPV, 1);
      rxEv.frameLost = 1'b1;
      pulseEv(EV_FT, 1);
      rxEv.frameLost = 1'b0;
      toTick();
      cntChk(16'h0002, 12'h002, 12'h001);
      $display("test counting done");
      cfg = 5'b10100;
      rxEv = rxEv | (EV_BPV | EV_CRC | EV_FPS);
      cyc(65540);
      rxEv = rxEv & ~(EV_BPV | EV_CRC | EV_FPS);
      toTick();
      cntChk(16'hFFFF, 12'hFFF, 12'hFFF);
      toTick();
      cntChk(16'h0000, 12'h000, 12'h000);
      $display("test saturation done");
      print_verdict();
   end
endmodule : tb_t1_status_irq_error_counters
`default_nettype wire
